// file: design/bpg_cfg.svh
/*
 Offsets, fields, reset values and timing counts of the gating block.
 Assumes a 100 MHz clock and byte addresses on the register bus.
*/
`ifndef BPG_CFG_SVH
`define BPG_CFG_SVH

// Clock and lock timing
`define BPG_CLK_FREQ_MHZ          100
`define BPG_LOCK_OPERATE_TIME_US  2000
`define BPG_LOCK_RECOVERY_TIME_US 12000
`define BPG_LOCK_OPERATE_CYCLES   (`BPG_LOCK_OPERATE_TIME_US * `BPG_CLK_FREQ_MHZ)
`define BPG_LOCK_RECOVERY_CYCLES  (`BPG_LOCK_RECOVERY_TIME_US * `BPG_CLK_FREQ_MHZ)

// Register byte offsets
`define BPG_ADDR_STATUS      5'h00
`define BPG_ADDR_IRQ_STATUS  5'h04
`define BPG_ADDR_IRQ_ENABLE  5'h08
`define BPG_ADDR_IRQ_CLEAR   5'h0C
`define BPG_ADDR_CONTROL     5'h10

// Live status fields
`define BPG_ST_UNDERVOLTAGE  0
`define BPG_ST_THERMAL       1
`define BPG_ST_SHUTDOWN      2
`define BPG_ST_LOCKED        3
`define BPG_ST_STOPPED       4
`define BPG_ST_ALL_OFF       5
`define BPG_ST_HALL_SUPPLY   6
`define BPG_ST_HALL_LSB      8
`define BPG_ST_WIDTH         11

// Event fields, shared by status, enable and clear registers
`define BPG_EV_UNDERVOLTAGE  0
`define BPG_EV_THERMAL       1
`define BPG_EV_SHUTDOWN      2
`define BPG_EV_LOCK          3
`define BPG_EV_LOCK_RELEASE  4
`define BPG_EV_WIDTH         5

// Control fields and reset values
`define BPG_CTL_FORCE_OFF    0
`define BPG_IRQ_ENABLE_RESET 5'h00
`define BPG_CONTROL_RESET    1'h0

`endif

// file: design/bpg_pkg.sv
/*
 Types of the protection and gating block.
 Assumes bpg_cfg.svh is available on the include path.
*/
package bpg_pkg;

    // Motor-lock supervisor states
    typedef enum logic [0:0] {
        BPG_LOCK_WATCH,
        BPG_LOCK_HOLD
    } bpg_lock_state_type;

    // Hall code, U in bit 2, V in bit 1, W in bit 0
    typedef logic [2:0] bpg_hall_type;

endpackage

// file: design/bpg_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs are asynchronous to clk; the output changes only once the
 second and third stages agree.
*/
`timescale 1ns/1ps
module bpg_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Shift chain; stage1 is read by stage2 alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Agreement filter per bit, so a one-cycle glitch never gets through
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sync_out[i] <= 1'b0;
            end else if (stage2[i] == stage3[i]) begin
                sync_out[i] <= stage2[i];
            end
        end
    end

endmodule // bpg_sync

// file: design/bpg_top.sv
/*
 Protection and gating logic of a three-phase brushless motor driver:
 Hall commutation, PWM gating of the top arm, protection latches with
 hysteresis, motor-lock supervision and an Avalon-MM register slave.
 Assumes external analog comparators deliver each threshold as a level and
 an external saw comparator delivers the PWM level; all of them are
 asynchronous to clk.
*/
// How it works
// - Supply below undervoltage operate level forces all six switches off.
// - Undervoltage lockout releases only when supply rises above recovery level.
// - Speed command below saw low level turns top arm off, bottom follows table.
// - Speed command below all-off level turns all six switches off.
// - Three-pulse monitor constant for lock operate time declares lock, all off.
// - Lock keeps switches off for recovery time, then normal operation resumes.
// - Lock detection suppressed by low speed command, undervoltage, thermal or shutdown.
// - Die above thermal operate level with protection enabled forces all off.
// - Thermal shutdown releases only when die falls below recovery level or protection is disabled.
// - Hall supply is on only while speed command is above all-off level.
// - Hall supply off means Hall inputs read low and both monitors low.
// - Shutdown input at operate level turns all six switches off.
// - Shutdown releases once the input falls below the recovery level.
// - Six Hall codes enable one top, one bottom switch; 000 and 111 none.
// - Modulation gates top-arm enables only; bottom arm follows decode directly.
`timescale 1ns/1ps
`include "bpg_cfg.svh"
module bpg_top
    import bpg_pkg::*;
#(
    parameter int LOCK_OPERATE_CYCLES  = `BPG_LOCK_OPERATE_CYCLES,
    parameter int LOCK_RECOVERY_CYCLES = `BPG_LOCK_RECOVERY_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Hall sensor comparators
    input  wire logic        hall_u,
    input  wire logic        hall_v,
    input  wire logic        hall_w,
    // Supply comparators
    input  wire logic        vcc_below_operate,
    input  wire logic        vcc_above_recovery,
    // Speed command comparators and saw comparator
    input  wire logic        speed_below_saw_low,
    input  wire logic        speed_below_all_off,
    input  wire logic        speed_lock_inhibit,
    input  wire logic        pwm_on,
    // Thermal comparators and select pin
    input  wire logic        temp_above_operate,
    input  wire logic        temp_below_recovery,
    input  wire logic        thermal_protect_select,
    // Shutdown comparators
    input  wire logic        shutdown_at_operate,
    input  wire logic        shutdown_below_recovery,
    // Bridge gate enables, bit 0 U, bit 1 V, bit 2 W
    output logic [2:0]       top_enable,
    output logic [2:0]       bottom_enable,
    // Hall supply and speed monitors
    output logic             hall_supply_output,
    output logic             speed_monitor_three_pulse,
    output logic             speed_monitor_single_pulse,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq
);

    localparam int CW = $clog2(((LOCK_OPERATE_CYCLES > LOCK_RECOVERY_CYCLES) ?
                                LOCK_OPERATE_CYCLES : LOCK_RECOVERY_CYCLES) + 1);
    localparam logic [CW-1:0] OPERATE_LAST  = CW'(LOCK_OPERATE_CYCLES - 1);
    localparam logic [CW-1:0] RECOVERY_LAST = CW'(LOCK_RECOVERY_CYCLES - 1);

    // Synchronised comparator levels
    logic [13:0]             raw_in;
    logic [13:0]             sync_in;
    bpg_hall_type            hall_sync;
    logic                    s_vcc_below;
    logic                    s_vcc_above;
    logic                    s_saw_low;
    logic                    s_all_off_level;
    logic                    s_lock_inhibit;
    logic                    s_pwm_on;
    logic                    s_temp_above;
    logic                    s_temp_below;
    logic                    s_ot_select;
    logic                    s_sd_at;
    logic                    s_sd_below;

    // Protection state
    logic                    undervoltage;
    logic                    thermal;
    logic                    shutdown;
    logic                    next_undervoltage;
    logic                    next_thermal;
    logic                    next_shutdown;
    logic                    thermal_enabled;
    logic                    next_all_off;
    logic                    hall_supply_on;

    // Lock supervision
    bpg_lock_state_type      lock_state;
    bpg_lock_state_type      next_lock_state;
    logic [CW-1:0]           lock_timer;
    logic [CW-1:0]           next_lock_timer;
    logic                    lock_suppress;
    logic                    monitor_prev;
    logic                    monitor_edge;
    logic                    locked;
    logic                    next_locked;

    // Commutation
    bpg_hall_type            hall_eff;
    logic [5:0]              comm;
    logic                    monitor_three;

    // Registers and interrupts
    logic [`BPG_EV_WIDTH-1:0] irq_status;
    logic [`BPG_EV_WIDTH-1:0] next_irq_status;
    logic [`BPG_EV_WIDTH-1:0] irq_enable;
    logic [`BPG_EV_WIDTH-1:0] events;
    logic [`BPG_EV_WIDTH-1:0] clear_mask;
    logic                    force_off;
    logic [`BPG_ST_WIDTH-1:0] live_status;
    logic                    bus_request;
    logic                    bus_accept;

    // Hall code to {top W,V,U, bottom W,V,U}; 000 and 111 give no switch
    function automatic logic [5:0] commutate(input bpg_hall_type code);
        logic [5:0] sel;
        sel = 6'h00;
        case (code)
            3'b101:  sel = 6'b010_001;  // V top, U bottom
            3'b100:  sel = 6'b100_001;  // W top, U bottom
            3'b110:  sel = 6'b100_010;  // W top, V bottom
            3'b010:  sel = 6'b001_010;  // U top, V bottom
            3'b011:  sel = 6'b001_100;  // U top, W bottom
            3'b001:  sel = 6'b010_100;  // V top, W bottom
            default: sel = 6'h00;
        endcase
        return sel;
    endfunction

    // All comparator outputs are asynchronous, one synchroniser for the lot
    assign raw_in = {hall_u, hall_v, hall_w, vcc_below_operate, vcc_above_recovery,
                     speed_below_saw_low, speed_below_all_off, speed_lock_inhibit,
                     pwm_on, temp_above_operate, temp_below_recovery,
                     thermal_protect_select, shutdown_at_operate, shutdown_below_recovery};

    bpg_sync #(
        .WIDTH    (14)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    assign hall_sync       = sync_in[13:11];
    assign s_vcc_below     = sync_in[10];
    assign s_vcc_above     = sync_in[9];
    assign s_saw_low       = sync_in[8];
    assign s_all_off_level = sync_in[7];
    assign s_lock_inhibit  = sync_in[6];
    assign s_pwm_on        = sync_in[5];
    assign s_temp_above    = sync_in[4];
    assign s_temp_below    = sync_in[3];
    assign s_ot_select     = sync_in[2];
    assign s_sd_at         = sync_in[1];
    assign s_sd_below      = sync_in[0];

    // Hysteresis latches: trip on the operate comparator, release on recovery
    assign next_undervoltage = s_vcc_below | (undervoltage & ~s_vcc_above);
    assign thermal_enabled   = ~s_ot_select;
    assign next_thermal      = thermal_enabled &
                               (s_temp_above | (thermal & ~s_temp_below));
    assign next_shutdown     = s_sd_at | (shutdown & ~s_sd_below);

    // Undervoltage starts tripped so the bridge stays off until supply is proven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            undervoltage <= 1'b1;
            thermal      <= 1'b0;
            shutdown     <= 1'b0;
        end else begin
            undervoltage <= next_undervoltage;
            thermal      <= next_thermal;
            shutdown     <= next_shutdown;
        end
    end

    // Hall supply standby; with the supply off the sensors read as all low
    assign hall_supply_on = ~s_all_off_level;
    assign hall_eff       = hall_supply_on ? hall_sync : 3'h0;
    assign comm           = commutate(hall_eff);

    // Three-pulse monitor is the majority of the three Hall phases
    assign monitor_three = (hall_eff[2] & hall_eff[1]) | (hall_eff[2] & hall_eff[0]) |
                           (hall_eff[1] & hall_eff[0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_prev <= 1'b0;
        end else begin
            monitor_prev <= monitor_three;
        end
    end

    assign monitor_edge  = monitor_three ^ monitor_prev;
    assign lock_suppress = s_lock_inhibit | next_undervoltage |
                           next_thermal | next_shutdown;

    // Lock supervisor; once holding, suppression does not cut the recovery short
    always_comb begin
        next_lock_state = lock_state;
        next_lock_timer = lock_timer;
        case (lock_state)
            BPG_LOCK_WATCH: begin
                if (lock_suppress || monitor_edge) begin
                    next_lock_timer = '0;
                end else if (lock_timer == OPERATE_LAST) begin
                    next_lock_state = BPG_LOCK_HOLD;
                    next_lock_timer = '0;
                end else begin
                    next_lock_timer = lock_timer + 1'b1;
                end
            end
            BPG_LOCK_HOLD: begin
                if (lock_timer == RECOVERY_LAST) begin
                    next_lock_state = BPG_LOCK_WATCH;
                    next_lock_timer = '0;
                end else begin
                    next_lock_timer = lock_timer + 1'b1;
                end
            end
            default: begin
                next_lock_state = BPG_LOCK_WATCH;
                next_lock_timer = '0;
            end
        endcase
    end

    assign next_locked = (next_lock_state == BPG_LOCK_HOLD);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_state <= BPG_LOCK_WATCH;
            lock_timer <= '0;
            locked     <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            lock_timer <= next_lock_timer;
            locked     <= next_locked;
        end
    end

    // One gate for every protection, built from next values so it lands with them
    assign next_all_off = next_undervoltage | next_thermal | next_shutdown |
                          next_locked | s_all_off_level | force_off;

    // Gate drive; PWM and the stop level touch the top arm only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_enable    <= 3'h0;
            bottom_enable <= 3'h0;
        end else begin
            top_enable    <= comm[5:3] &
                             {3{s_pwm_on & ~s_saw_low & ~next_all_off}};
            bottom_enable <= comm[2:0] & {3{~next_all_off}};
        end
    end

    // Hall supply and speed monitors
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hall_supply_output         <= 1'b0;
            speed_monitor_three_pulse  <= 1'b0;
            speed_monitor_single_pulse <= 1'b0;
        end else begin
            hall_supply_output         <= hall_supply_on;
            speed_monitor_three_pulse  <= monitor_three;
            speed_monitor_single_pulse <= hall_eff[2];
        end
    end

    // Events are entries into each protection and the lock release
    always_comb begin
        events = '0;
        events[`BPG_EV_UNDERVOLTAGE] = next_undervoltage & ~undervoltage;
        events[`BPG_EV_THERMAL]      = next_thermal & ~thermal;
        events[`BPG_EV_SHUTDOWN]     = next_shutdown & ~shutdown;
        events[`BPG_EV_LOCK]         = next_locked & ~locked;
        events[`BPG_EV_LOCK_RELEASE] = locked & ~next_locked;
    end

    // Bus handshake: one wait cycle, then the transfer completes
    assign bus_request = avs_read | avs_write;
    assign bus_accept  = bus_request & ~avs_waitrequest;

    always_comb begin
        clear_mask = '0;
        if (bus_accept && avs_write && avs_address == `BPG_ADDR_IRQ_CLEAR &&
            avs_byteenable[0]) begin
            clear_mask = avs_writedata[`BPG_EV_WIDTH-1:0];
        end
    end

    // A new event outranks a clear written in the same cycle
    assign next_irq_status = (irq_status & ~clear_mask) | events;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_enable);
        end
    end

    // Writable registers, low byte lane carries every field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= `BPG_IRQ_ENABLE_RESET;
            force_off  <= `BPG_CONTROL_RESET;
        end else if (bus_accept && avs_write && avs_byteenable[0]) begin
            if (avs_address == `BPG_ADDR_IRQ_ENABLE) begin
                irq_enable <= avs_writedata[`BPG_EV_WIDTH-1:0];
            end
            if (avs_address == `BPG_ADDR_CONTROL) begin
                force_off <= avs_writedata[`BPG_CTL_FORCE_OFF];
            end
        end
    end

    // Live view of the block
    always_comb begin
        live_status = '0;
        live_status[`BPG_ST_UNDERVOLTAGE] = undervoltage;
        live_status[`BPG_ST_THERMAL]      = thermal;
        live_status[`BPG_ST_SHUTDOWN]     = shutdown;
        live_status[`BPG_ST_LOCKED]       = locked;
        live_status[`BPG_ST_STOPPED]      = s_saw_low;
        live_status[`BPG_ST_ALL_OFF]      = next_all_off;
        live_status[`BPG_ST_HALL_SUPPLY]  = hall_supply_on;
        live_status[`BPG_ST_HALL_LSB +: 3] = hall_eff;
    end

    // Wait state and read data; unmapped and write-only offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_request & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `BPG_ADDR_STATUS:     avs_readdata <= 32'(live_status);
                    `BPG_ADDR_IRQ_STATUS: avs_readdata <= 32'(irq_status);
                    `BPG_ADDR_IRQ_ENABLE: avs_readdata <= 32'(irq_enable);
                    `BPG_ADDR_CONTROL:    avs_readdata <= 32'(force_off);
                    default:              avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // bpg_top

// file: verification/bpg_checker_assertions.sv
/* Checker on the ports of bpg_top: gates against held causes.
   Assumes any input reaches the gates within five edges. */
`timescale 1ns/1ps
module bpg_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Causes
    input wire logic       vcc_below_operate,
    input wire logic       speed_below_saw_low,
    input wire logic       speed_below_all_off,
    input wire logic       pwm_on,
    input wire logic       temp_above_operate,
    input wire logic       thermal_protect_select,
    input wire logic       shutdown_at_operate,
    input wire logic       avs_read,
    input wire logic       avs_write,
    // Effects
    input wire logic [2:0] top_enable,
    input wire logic [2:0] bottom_enable,
    input wire logic       hall_supply_output,
    input wire logic       speed_monitor_three_pulse,
    input wire logic       speed_monitor_single_pulse,
    input wire logic       avs_waitrequest
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Five samples cover the filter and the output flop
    sequence s_held(cond);
        cond [*5];
    endsequence
    // Both arms dark once the cause has settled
    property p_dark(cond);
        s_held(cond) |=> top_enable == 3'h0 && bottom_enable == 3'h0;
    endproperty
    AST_UV_DARK: assert property (p_dark(vcc_below_operate))
        else $error("gates on in undervoltage");
    AST_VSP_DARK: assert property (p_dark(speed_below_all_off))
        else $error("gates on below all-off level");
    AST_HOT_DARK: assert property (p_dark(temp_above_operate && !thermal_protect_select))
        else $error("gates on while hot");
    AST_SD_DARK: assert property (p_dark(shutdown_at_operate))
        else $error("gates on in shutdown");
    AST_SAW_TOP: assert property (s_held(speed_below_saw_low) |=> top_enable == 3'h0)
        else $error("top arm on below saw level");
    AST_PWM_TOP: assert property (s_held(!pwm_on) |=> top_enable == 3'h0)
        else $error("top arm on with modulation low");
    AST_HALL_OFF: assert property (s_held(speed_below_all_off) |=>
        !hall_supply_output && !speed_monitor_three_pulse && !speed_monitor_single_pulse)
        else $error("hall outputs on in standby");
    AST_ONE_PAIR: assert property ($onehot0(top_enable) && $onehot0(bottom_enable)
        && (top_enable & bottom_enable) == 3'h0)
        else $error("bad switch pair");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
endmodule // bpg_checker

bind bpg_top bpg_checker u_chk (.*);

// file: verification/bpg_motor_model.sv
/* Motor side model: Hall levels of a turning or stalled rotor, thermal strap.
   Assumes the block's clock; one Hall step per eight cycles when turning. */
`timescale 1ns/1ps
module bpg_motor_model (
    // Clock
    input  wire logic       clk,
    // Stalled position, turn request, strap choice
    input  wire logic [2:0] hall_code,
    input  wire logic       spin,
    input  wire logic       thermal_used,
    // Sensor and strap levels
    output logic            hall_u,
    output logic            hall_v,
    output logic            hall_w,
    output logic            thermal_protect_select
);
    localparam logic [17:0] ROT = {3'h1, 3'h3, 3'h6, 3'h2, 3'h4, 3'h5};
    logic [2:0] code = 3'h5;
    logic [2:0] step = 3'h0;
    logic [2:0] div  = 3'h0;
    // Rotor steps through the six valid codes; a stall holds one code
    always_ff @(posedge clk) begin
        div  <= div + 3'h1;
        if (spin && div == 3'h7) step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
        code <= spin ? ROT[3*step +: 3] : hall_code;
    end
    assign {hall_u, hall_v, hall_w} = code;
    // Strap to ground enables thermal protection, to the supply disables it
    assign thermal_protect_select = !thermal_used;
endmodule // bpg_motor_model

// file: verification/tb.sv
/* Self-checking bench for bpg_top: table, protections, lock, registers.
   Assumes the motor model supplies Hall levels and the thermal strap. */
`timescale 1ns/1ps
`include "bpg_cfg.svh"
module tb;
    localparam int OPC  = 20;
    localparam int RECC = 50;
    localparam logic [2:0] TT [8] = '{3'h0, 3'h2, 3'h1, 3'h1, 3'h4, 3'h2, 3'h4, 3'h0};
    localparam logic [2:0] BT [8] = '{3'h0, 3'h4, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0};
    logic        clk = 1'b0, rst_n = 1'b0;
    logic [2:0]  hall_code = 3'h5;
    logic        spin = 1'b0, thermal_used = 1'b1;
    logic [2:0]  op = 3'h1;  // Operate levels: supply, thermal, shutdown
    logic [2:0]  rec = 3'h6; // Recovery levels, same order
    logic        saw_low = 1'b0, all_off = 1'b0, inhibit = 1'b1, pwm_on = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        hall_u, hall_v, hall_w, thermal_protect_select, avs_waitrequest, irq;
    logic [2:0]  top_enable, bottom_enable;
    logic        hall_supply_output, speed_monitor_three_pulse, speed_monitor_single_pulse;
    logic [31:0] avs_readdata, q;
    int          n_fail = 0, n_tests = 0;

    bpg_motor_model u_motor (.*);
    bpg_top #(.LOCK_OPERATE_CYCLES(OPC), .LOCK_RECOVERY_CYCLES(RECC)) u_dut (.*,
        .vcc_below_operate(op[0]), .vcc_above_recovery(rec[0]), .avs_byteenable(4'hF),
        .speed_below_saw_low(saw_low), .speed_below_all_off(all_off),
        .speed_lock_inhibit(inhibit), .temp_above_operate(op[1]), .temp_below_recovery(rec[1]),
        .shutdown_at_operate(op[2]), .shutdown_below_recovery(rec[2]));

    // Clock, 10 ns period
    initial forever #5 clk = ~clk;

    task automatic tally_and_finish;
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Compare once sync and output flops settle
    task automatic gate(input logic [2:0] t, input logic [2:0] b, input logic [2:0] m);
        cyc(8);
        #1;
        cmp("top_enable", {29'h0, t}, {29'h0, top_enable});
        cmp("bottom_enable", {29'h0, b}, {29'h0, bottom_enable});
        cmp("hall outputs", {29'h0, m}, {29'h0, hall_supply_output,
            speed_monitor_three_pulse, speed_monitor_single_pulse});
        @(posedge clk);
    endtask
    // Request held until waitrequest is sampled low; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        cmp("wait edges", 32'h2, i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string s, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(s, e, q);
    endtask
    task automatic chk_irq(input logic v);
        cyc(2);
        #1;
        cmp("irq", {31'h0, v}, {31'h0, irq});
    endtask
    // Edges spent with the bottom arm off, or on
    task automatic dwell(input logic off, output int n);
        n = 0;
        while (((bottom_enable === 3'h0) == off) && n < 500) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        int n;
        cyc(10);
        rst_n <= 1'b1;
        gate(3'h0, 3'h0, 3'h7);
        op[0] <= 1'b0;
        gate(3'h0, 3'h0, 3'h7);
        rec[0] <= 1'b1;
        gate(3'h2, 3'h1, 3'h7);
        for (int c = 0; c < 8; c++) begin
            hall_code <= 3'(c);
            gate(TT[c], BT[c], {1'b1, (c[0] & c[1]) | (c[1] & c[2]) | (c[0] & c[2]), c[2]});
        end
        hall_code <= 3'h5;
        pwm_on <= 1'b0;
        gate(3'h0, 3'h1, 3'h7);
        pwm_on <= 1'b1;
        saw_low <= 1'b1;
        gate(3'h0, 3'h1, 3'h7);
        all_off <= 1'b1;
        gate(3'h0, 3'h0, 3'h0);
        hall_code <= 3'h7;
        gate(3'h0, 3'h0, 3'h0);
        {saw_low, all_off, hall_code} <= 5'h05;
        gate(3'h2, 3'h1, 3'h7);
        wr(`BPG_ADDR_IRQ_CLEAR, 32'h1F);
        for (int p = 0; p < 3; p++) begin
            {op[p], rec[p]} <= 2'b10;
            gate(3'h0, 3'h0, 3'h7);
            op[p] <= 1'b0;
            gate(3'h0, 3'h0, 3'h7);
            rec[p] <= 1'b1;
            gate(3'h2, 3'h1, 3'h7);
        end
        {thermal_used, op[1], rec[1]} <= 3'b010;
        gate(3'h2, 3'h1, 3'h7);
        {thermal_used, op[1], rec[1]} <= 3'b101;
        rdc("irq_status", `BPG_ADDR_IRQ_STATUS, 32'h7);
        wr(`BPG_ADDR_IRQ_ENABLE, 32'h4);
        chk_irq(1'b1);
        rdc("irq_enable", `BPG_ADDR_IRQ_ENABLE, 32'h4);
        wr(`BPG_ADDR_IRQ_ENABLE, 32'h0);
        chk_irq(1'b0);
        wr(`BPG_ADDR_IRQ_CLEAR, 32'h7);
        rdc("irq_status", `BPG_ADDR_IRQ_STATUS, 32'h0);
        rdc("irq_clear", `BPG_ADDR_IRQ_CLEAR, 32'h0);
        rdc("unmapped", 5'h14, 32'h0);
        wr(`BPG_ADDR_CONTROL, 32'h1);
        gate(3'h0, 3'h0, 3'h7);
        rdc("control", `BPG_ADDR_CONTROL, 32'h1);
        wr(`BPG_ADDR_CONTROL, 32'h0);
        gate(3'h2, 3'h1, 3'h7);
        // Turning rotor keeps restarting the lock timer; a stall trips it once inhibit drops
        {inhibit, spin} <= 2'b01;
        cyc(100);
        cmp("bottom busy", 32'h1, {31'h0, bottom_enable != 3'h0});
        wr(`BPG_ADDR_IRQ_CLEAR, 32'h1F);
        {inhibit, spin} <= 2'b10;
        cyc(20);
        inhibit <= 1'b0;
        dwell(1'b0, n);
        cmp("lock delay", 32'h1, {31'h0, n >= OPC && n <= OPC + 15});
        dwell(1'b1, n);
        cmp("lock hold", 32'h1, {31'h0, n >= RECC - 2 && n <= RECC + 2});
        rdc("irq_status", `BPG_ADDR_IRQ_STATUS, 32'h18);
        inhibit <= 1'b1;
        dwell(1'b0, n);
        cmp("lock suppressed", 32'h1F4, n);
        gate(3'h2, 3'h1, 3'h7);
        tally_and_finish;
    end

    // Watchdog, far past the run's length
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule // tb
